// ### logic/bnr_router.sv
// Purpose: Routes VME interrupt levels to SBus levels and merges NMI sources.
// Assumes: VME and switch inputs synchronous to core_clk, active high.
// Notes: Acknowledge is a simple request/done handshake with the VME side.
`timescale 1ns/100ps
`default_nettype none
module bnr_router #(
    parameter int NLVL = 7
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NLVL:1] vme_irq,
    output logic [2:0] iack_level,
    output logic iack_req,
    input wire logic iack_done,
    input wire logic [7:0] iack_vector,
    input wire logic sysfail,
    input wire logic acfail,
    input wire logic abort_sw,
    output logic [15:1] sbus_irq,
    output logic [3:0] proc_irl,
    output logic board_reset,
    output logic irq
);
    // Register state
    logic [31:0] route_reg;
    logic [NLVL:1] ven_reg;
    logic [31:0] gpr2_reg;
    logic [1:0] wdctl_reg;
    logic [31:0] wdper_reg;
    logic [31:0] wdcnt_reg;
    logic half_done_reg;
    logic [bnr_pkg::NUM_ST-1:0] ien_reg;
    logic vec_flag_reg;
    logic [7:0] vec_reg;
    bnr_pkg::bnr_ack_t ack_state_reg;
    logic [2:0] ack_lvl_reg;
    logic aw_got_reg, w_got_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic board_reset_reg;

    // Write channel acceptance: address and data taken in either order
    assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_got_reg & ~bvalid_reg;
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_got_reg & w_got_reg;
    wire [7:0] wa = aw_addr_reg;
    wire wr_route = wr_go && wa == bnr_pkg::ADDR_ROUTE;
    wire wr_ven = wr_go && wa == bnr_pkg::ADDR_VEN;
    wire wr_gpr2 = wr_go && wa == bnr_pkg::ADDR_GPR2;
    wire wr_wdctl = wr_go && wa == bnr_pkg::ADDR_WDCTL;
    wire wr_wdper = wr_go && wa == bnr_pkg::ADDR_WDPER;
    wire wr_clr = wr_go && wa == bnr_pkg::ADDR_CLR;
    wire wr_ien = wr_go && wa == bnr_pkg::ADDR_IEN;
    wire wr_ack = wr_go && wa == bnr_pkg::ADDR_ACK;
    wire wr_stat = wr_go && wa == bnr_pkg::ADDR_STAT;
    wire wr_vec = wr_go && wa == bnr_pkg::ADDR_VEC;
    wire wr_pend = wr_go && wa == bnr_pkg::ADDR_PEND;
    wire wr_ok = wr_route | wr_ven | wr_gpr2 | wr_wdctl | wr_wdper | wr_clr | wr_ien | wr_ack
                 | wr_stat | wr_vec | wr_pend;
    // Restart is a write-one pulse and is never stored
    wire wr_kick = wr_wdctl & w_strb_reg[0] & w_data_reg[bnr_pkg::WD_KICK_BIT];

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    wire [31:0] route_next = merge(route_reg, w_data_reg, w_strb_reg);
    wire [31:0] ven_next = merge({{(32-NLVL){1'b0}}, ven_reg}, w_data_reg, w_strb_reg);
    wire [31:0] gpr2_next = merge(gpr2_reg, w_data_reg, w_strb_reg);
    wire [31:0] wdper_next = merge(wdper_reg, w_data_reg, w_strb_reg);
    wire [31:0] wdctl_next = merge({30'h0, wdctl_reg}, w_data_reg, w_strb_reg);
    wire [31:0] ien_next = merge({{(32-bnr_pkg::NUM_ST){1'b0}}, ien_reg}, w_data_reg, w_strb_reg);
    wire [31:0] clr_val = merge(32'h0, w_data_reg, w_strb_reg);

    // Shared NMI gate and watchdog controls
    wire nmi_shared_gate_enable = gpr2_reg[bnr_pkg::NMI_GATE_BIT];
    wire wd_ena = wdctl_reg[bnr_pkg::WD_ENA_BIT];
    wire wd_nmi_ena = wdctl_reg[bnr_pkg::WD_NMI_BIT];

    // Watchdog half and full marks
    // An odd period rounds the half mark down
    wire [31:0] half_mark = {1'b0, wdper_reg[31:1]};
    wire half_hit = wd_ena & ~half_done_reg & (wdcnt_reg >= half_mark);
    wire full_hit = wd_ena & (wdcnt_reg >= wdper_reg - 32'h1);

    // NMI source latches; edges come from the raw pins and are gated before latching,
    // so opening or closing the gate while a source is held never counts as an edge
    wire [bnr_pkg::NUM_ST-1:0] clr_bits = wr_clr ? clr_val[bnr_pkg::NUM_ST-1:0] : '0;
    wire sf_ev, ac_ev, ab_ev;
    logic sf_flag, ac_flag, ab_flag, wd_flag;
    bnr_edge #(
        .RISE(1'b1),
        .FALL(1'b1)
    ) u_sysfail (
        .core_clk(core_clk),
        .nrst(nrst),
        .level(sysfail),
        .ena(nmi_shared_gate_enable),
        .clr(clr_bits[bnr_pkg::ST_SYSFAIL]),
        .event_p(sf_ev),
        .flag(sf_flag)
    );
    bnr_edge #(
        .RISE(1'b1),
        .FALL(1'b0)
    ) u_acfail (
        .core_clk(core_clk),
        .nrst(nrst),
        .level(acfail),
        .ena(nmi_shared_gate_enable),
        .clr(clr_bits[bnr_pkg::ST_ACFAIL]),
        .event_p(ac_ev),
        .flag(ac_flag)
    );
    bnr_edge #(
        .RISE(1'b1),
        .FALL(1'b0)
    ) u_abort (
        .core_clk(core_clk),
        .nrst(nrst),
        .level(abort_sw),
        .ena(nmi_shared_gate_enable),
        .clr(clr_bits[bnr_pkg::ST_ABORT]),
        .event_p(ab_ev),
        .flag(ab_flag)
    );
    wire wd_ev = half_hit & wd_nmi_ena & nmi_shared_gate_enable;

    // Level 15 request: OR of latched sources under the shared gate
    wire nmi_req = nmi_shared_gate_enable & (sf_flag | ac_flag | ab_flag | wd_flag);

    // VME routing: each enabled level drives its chosen SBus level
    // Level code 0 parks a level unrouted without touching its enable
    logic [15:1] routed;
    always_comb begin
        routed = '0;
        for (int l = 1; l <= NLVL; l++) begin
            if (vme_irq[l] && ven_reg[l] && route_reg[(l-1)*4 +: 3] != 3'h0) begin
                routed[route_reg[(l-1)*4 +: 3]] = 1'b1;
            end
        end
        routed[bnr_pkg::NMI_LEVEL] = nmi_req;
    end
    assign sbus_irq = routed;

    // Highest active level to processor priority code
    logic [3:0] irl;
    always_comb begin
        irl = 4'h0;
        for (int k = 1; k <= 15; k++) begin
            if (routed[k]) begin
                irl = 4'(k);
            end
        end
    end
    assign proc_irl = irl;

    // Status word and the single level interrupt
    wire [bnr_pkg::NUM_ST-1:0] stat = {vec_flag_reg, wd_flag, ab_flag, ac_flag, sf_flag};
    assign irq = |(stat & ien_reg);
    assign iack_req = ack_state_reg == bnr_pkg::BNR_ACK_RUN;
    assign iack_level = ack_lvl_reg;
    assign board_reset = board_reset_reg;

    // Read decode
    wire [7:0] ra = s_axi_araddr[7:0];
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (ra)
            bnr_pkg::ADDR_ROUTE: rd_val = route_reg;
            bnr_pkg::ADDR_VEN: rd_val = {{(32-NLVL){1'b0}}, ven_reg};
            bnr_pkg::ADDR_GPR2: rd_val = gpr2_reg;
            bnr_pkg::ADDR_WDCTL: rd_val = {30'h0, wdctl_reg};
            bnr_pkg::ADDR_WDPER: rd_val = wdper_reg;
            bnr_pkg::ADDR_STAT: rd_val = {{(32-bnr_pkg::NUM_ST){1'b0}}, stat};
            bnr_pkg::ADDR_CLR: rd_val = 32'h0;
            bnr_pkg::ADDR_IEN: rd_val = {{(32-bnr_pkg::NUM_ST){1'b0}}, ien_reg};
            bnr_pkg::ADDR_ACK: rd_val = {28'h0, iack_req, ack_lvl_reg};
            bnr_pkg::ADDR_VEC: rd_val = {24'h0, vec_reg};
            bnr_pkg::ADDR_PEND: rd_val = {16'h0, routed, 1'b0};
            default: begin
                rd_val = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end
    // Read channel: one read in flight, answer registered
    wire ar_fire = s_axi_arvalid & s_axi_arready;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Bus channel state
    // Valids drop only once the master's ready has been seen with them
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= bnr_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= bnr_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[7:0];
            end
            if (w_fire) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? bnr_pkg::RESP_OKAY : bnr_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (ar_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_val;
                rresp_reg <= rd_ok ? bnr_pkg::RESP_OKAY : bnr_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Software registers; enables clear at reset so nothing fires until armed
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            route_reg <= 32'h0;
            ven_reg <= '0;
            gpr2_reg <= 32'h0;
            wdctl_reg <= 2'h0;
            wdper_reg <= bnr_pkg::WD_PERIOD_RST;
            ien_reg <= '0;
        end else begin
            if (wr_route) route_reg <= route_next;
            if (wr_ven) ven_reg <= ven_next[NLVL:1];
            if (wr_gpr2) gpr2_reg <= gpr2_next;
            if (wr_wdctl) wdctl_reg <= wdctl_next[1:0];
            if (wr_wdper) wdper_reg <= wdper_next;
            if (wr_ien) ien_reg <= ien_next[bnr_pkg::NUM_ST-1:0];
        end
    end

    // Watchdog counter; a kick or new enable restarts the period
    // A kick in the expiry cycle still lets the reset pulse out, so software must kick earlier
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wdcnt_reg <= 32'h0;
            half_done_reg <= 1'b0;
            wd_flag <= 1'b0;
            board_reset_reg <= 1'b0;
        end else begin
            board_reset_reg <= full_hit;
            if (!wd_ena || wr_kick || full_hit) begin
                wdcnt_reg <= 32'h0;
                half_done_reg <= 1'b0;
            end else begin
                wdcnt_reg <= wdcnt_reg + 32'h1;
                if (half_hit) half_done_reg <= 1'b1;
            end
            wd_flag <= wd_ev | (wd_flag & ~clr_bits[bnr_pkg::ST_WDHALF]);
        end
    end

    // Acknowledge sequencer: software picks a level, vector is captured on done
    // Only one acknowledge runs at a time; a request written during a run is dropped
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_state_reg <= bnr_pkg::BNR_ACK_IDLE;
            ack_lvl_reg <= 3'h0;
            vec_reg <= 8'hff;
            vec_flag_reg <= 1'b0;
        end else begin
            vec_flag_reg <= vec_flag_reg & ~clr_bits[bnr_pkg::ST_VEC];
            case (ack_state_reg)
                bnr_pkg::BNR_ACK_IDLE: begin
                    if (wr_ack && w_data_reg[2:0] != 3'h0) begin
                        ack_lvl_reg <= w_data_reg[2:0];
                        ack_state_reg <= bnr_pkg::BNR_ACK_RUN;
                    end
                end
                bnr_pkg::BNR_ACK_RUN: begin
                    if (iack_done) begin
                        vec_reg <= iack_vector;
                        vec_flag_reg <= 1'b1;
                        ack_state_reg <= bnr_pkg::BNR_ACK_DONE;
                    end
                end
                bnr_pkg::BNR_ACK_DONE: ack_state_reg <= bnr_pkg::BNR_ACK_IDLE;
                default: ack_state_reg <= bnr_pkg::BNR_ACK_IDLE;
            endcase
        end
    end
endmodule : bnr_router
`default_nettype wire

// ### logic/bnr_pkg.sv
// Purpose: Constants for the on-board NMI and VME interrupt router.
// Assumes: 100 MHz core clock, AXI4-Lite register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package bnr_pkg;
    localparam logic [7:0] ADDR_ROUTE = 8'h00;
    localparam logic [7:0] ADDR_VEN = 8'h04;
    localparam logic [7:0] ADDR_GPR2 = 8'h08;
    localparam logic [7:0] ADDR_WDCTL = 8'h0c;
    localparam logic [7:0] ADDR_WDPER = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_CLR = 8'h18;
    localparam logic [7:0] ADDR_IEN = 8'h1c;
    localparam logic [7:0] ADDR_ACK = 8'h20;
    localparam logic [7:0] ADDR_VEC = 8'h24;
    localparam logic [7:0] ADDR_PEND = 8'h28;
    localparam int NMI_GATE_BIT = 2;
    localparam int WD_ENA_BIT = 0;
    localparam int WD_NMI_BIT = 1;
    localparam int WD_KICK_BIT = 2;
    localparam int NMI_LEVEL = 15;
    // Status bit positions
    localparam int ST_SYSFAIL = 0;
    localparam int ST_ACFAIL = 1;
    localparam int ST_ABORT = 2;
    localparam int ST_WDHALF = 3;
    localparam int ST_VEC = 4;
    localparam int NUM_ST = 5;
    localparam logic [31:0] WD_PERIOD_RST = 32'h05f5e100;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        BNR_ACK_IDLE = 2'b00,
        BNR_ACK_RUN = 2'b01,
        BNR_ACK_DONE = 2'b10
    } bnr_ack_t;
endpackage : bnr_pkg

// ### logic/bnr_edge.sv
// Purpose: Sticky event latch with edge detection for one NMI source.
// Assumes: Input already synchronous to core_clk.
// Notes: Set wins over clear in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module bnr_edge #(
    parameter bit RISE = 1'b1,
    parameter bit FALL = 1'b0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic level,
    input wire logic ena,
    input wire logic clr,
    output var logic event_p,
    output var logic flag
);
    logic prev_reg;
    // Edges are judged on the raw level, so moving the enable with the source held is never an edge
    assign event_p = ena & ((RISE & level & ~prev_reg) | (FALL & ~level & prev_reg));
    // Previous level and sticky flag
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
            flag <= 1'b0;
        end else begin
            prev_reg <= level;
            flag <= event_p | (flag & ~clr);
        end
    end
endmodule : bnr_edge
`default_nettype wire

// ### tb/bnr_props_properties.sv
// Purpose: Port-level checks of the interrupt router.
// Assumes: One clock domain; the master offers aw and w together.
// Notes: Sees only the top module's ports.
`timescale 1ns/100ps
`default_nettype none
module bnr_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic [2:0] iack_level,
    input wire logic iack_req,
    input wire logic iack_done,
    input wire logic sysfail,
    input wire logic acfail,
    input wire logic abort_sw,
    input wire logic [15:1] sbus_irq,
    input wire logic [3:0] proc_irl,
    input wire logic board_reset
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // Acknowledge steps: waiting, then answered
    sequence s_iack_wait;
        iack_req && !iack_done;
    endsequence
    sequence s_iack_answer;
        iack_req && iack_done;
    endsequence
    property p_iack_hold;
        s_iack_wait |=> iack_req && $stable(iack_level);
    endproperty
    a_iack_hold: assert property (p_iack_hold) else $error("ack dropped early");
    property p_iack_end;
        s_iack_answer |=> !iack_req;
    endproperty
    a_iack_end: assert property (p_iack_end) else $error("ack kept running");
    property p_irl_nmi;
        sbus_irq[15] |-> proc_irl == 4'hf;
    endproperty
    a_irl_nmi: assert property (p_irl_nmi) else $error("nmi not level 15");
    property p_irl_top;
        sbus_irq != 15'h0 |-> ({sbus_irq, 1'b0} >> proc_irl) == 16'h0001;
    endproperty
    a_irl_top: assert property (p_irl_top) else $error("wrong top level");
    property p_irl_none;
        sbus_irq == 15'h0 |-> proc_irl == 4'h0;
    endproperty
    a_irl_none: assert property (p_irl_none) else $error("level without request");
    property p_wd_pulse;
        board_reset |=> !board_reset [*8];
    endproperty
    a_wd_pulse: assert property (p_wd_pulse) else $error("reset pulse too long");
    // With no write offered, held or answered a latched request cannot vanish
    property p_nmi_sticky;
        sbus_irq[15] && s_axi_awready && !s_axi_awvalid && !s_axi_wvalid && !s_axi_bvalid |=> sbus_irq[15];
    endproperty
    a_nmi_sticky: assert property (p_nmi_sticky) else $error("nmi lost");
    property p_acfail_fall;
        $fell(acfail) && !sbus_irq[15] && $stable(sysfail) && $stable(abort_sw) && !abort_sw
            |=> !sbus_irq[15] [*3];
    endproperty
    a_acfail_fall: assert property (p_acfail_fall) else $error("nmi on power return");
endmodule : bnr_props
`default_nettype wire

// ### tb/bnr_vme_side.sv
// Purpose: Far side model: VME interrupters and acknowledge responder.
// Assumes: An interrupter holds its level until acknowledged.
// Notes: Vector lines carry junk outside the answer cycle.
`timescale 1ns/100ps
`default_nettype none
module bnr_vme_side (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:1] raise,
    input wire logic [3:0] delay,
    input wire logic [7:0] vec_base,
    input wire logic iack_req,
    input wire logic [2:0] iack_level,
    output logic [7:1] vme_irq,
    output logic iack_done,
    output logic [7:0] iack_vector
);
    logic [3:0] wait_cnt;
    wire logic answer = iack_req && !iack_done && wait_cnt == delay;
    wire logic [7:1] served = answer ? 7'h01 << (iack_level - 3'h1) : 7'h00;
    // Answer after a chosen delay; the served interrupter then lets go
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vme_irq <= 7'h00;
            wait_cnt <= 4'h0;
            iack_done <= 1'b0;
            iack_vector <= 8'h5a;
        end else begin
            vme_irq <= (vme_irq | raise) & ~served;
            wait_cnt <= (iack_req && !answer) ? wait_cnt + 4'h1 : 4'h0;
            iack_done <= answer;
            iack_vector <= answer ? vec_base ^ {5'h00, iack_level} : ~iack_vector;
        end
    end
endmodule : bnr_vme_side
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench of the interrupt router.
// Assumes: Reads and writes answered within 50 cycles.
// Notes: Watchdog period shortened to 20 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [7:0] VBASE = 8'h30;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:1] vme_irq, raise = 7'h00;
    logic [2:0] iack_level;
    logic [2:0] sb [1:7];
    logic iack_req, iack_done, board_reset, irq;
    logic sysfail = 1'b0, acfail = 1'b0, abort_sw = 1'b0;
    logic [7:0] iack_vector, ven;
    logic [15:1] sbus_irq;
    logic [3:0] proc_irl, delay = 4'h0;
    logic [31:0] route;
    int mismatches = 0, total_checks = 0, resets = 0, acks = 0, n;
    logic [33:0] expq [$];

    bnr_router i_dut (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .vme_irq, .iack_level, .iack_req, .iack_done, .iack_vector, .sysfail, .acfail,
        .abort_sw, .sbus_irq, .proc_irl, .board_reset, .irq);
    bnr_vme_side i_vme (.core_clk, .nrst, .raise, .delay, .vec_base(VBASE), .iack_req, .iack_level,
        .vme_irq, .iack_done, .iack_vector);

    always #5 core_clk = ~core_clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp

    task automatic hang();
        mismatches++;
        $display("CHECK FAILED at %0t: no answer", $time);
        tally_and_finish();
    endtask : hang

    // One bus cycle; the expected answer is queued for the monitor
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        @(posedge core_clk);
        expq.push_back({r, w ? 32'h0 : d});
        if (w) begin
            s_axi_awaddr <= {24'h0, a};
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= {24'h0, a};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (int i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid || s_axi_rvalid) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask : bus

    // Step one source, then expect status and level 15 to follow
    task automatic src(input int k, input logic v, input logic [31:0] st);
        case (k)
            0: sysfail <= v;
            1: acfail <= v;
            default: abort_sw <= v;
        endcase
        @(posedge core_clk);
        if (k == 2) abort_sw <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        cmp(proc_irl, st != 0 ? 4'hf : 4'h0);
        bus(0, bnr_pkg::ADDR_STAT, st);
        bus(1, bnr_pkg::ADDR_CLR, st);
    endtask : src

    // Answers are matched in order against what the driver expected
    always @(posedge core_clk) begin
        if (board_reset) resets++;
        if (iack_done) acks++;
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            if (expq.size() == 0) hang();
            cmp(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, expq.pop_front());
        end
    end

    initial begin
        void'($urandom(32'hb691));
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        bus(0, bnr_pkg::ADDR_VEC, 32'hff);
        bus(0, bnr_pkg::ADDR_GPR2, 32'h0);
        bus(0, bnr_pkg::ADDR_WDCTL, 32'h0);
        bus(0, 8'h40, 32'h0, bnr_pkg::RESP_SLVERR);
        bus(1, bnr_pkg::ADDR_WDPER, 32'h14);
        // Gate off: every source and the idle watchdog stay silent
        src(0, 1'b1, 32'h0);
        src(1, 1'b1, 32'h0);
        src(2, 1'b1, 32'h0);
        src(0, 1'b0, 32'h0);
        repeat (30) @(posedge core_clk);
        cmp(resets, 0);
        // Opening the gate while ACFAIL is held is no edge
        bus(1, bnr_pkg::ADDR_GPR2, 32'h1 << bnr_pkg::NMI_GATE_BIT);
        bus(0, bnr_pkg::ADDR_STAT, 32'h0);
        src(1, 1'b0, 32'h0);
        src(0, 1'b1, 32'h1);
        src(0, 1'b0, 32'h1);
        src(1, 1'b1, 32'h2);
        src(1, 1'b0, 32'h0);
        src(2, 1'b1, 32'h4);
        // Watchdog: half-time event, then restart and full expiry
        bus(1, bnr_pkg::ADDR_WDCTL, 32'h3);
        repeat (12) @(posedge core_clk);
        bus(0, bnr_pkg::ADDR_STAT, 32'h8);
        bus(1, bnr_pkg::ADDR_WDCTL, 32'h7);
        for (n = 0; n < 40 && resets == 0; n++) @(posedge core_clk);
        cmp(n > 15 && n < 23, 1'b1);
        bus(1, bnr_pkg::ADDR_WDCTL, 32'h0);
        bus(1, bnr_pkg::ADDR_CLR, 32'hf);
        // Random routing with at least one level masked; partner answers slow or fast
        route = 32'h0;
        for (int l = 1; l <= 7; l++) begin
            sb[l] = 3'($urandom_range(7, 1));
            route = route | (32'(sb[l]) << (4 * (l - 1)));
        end
        ven = {7'($urandom), 1'b0};
        ven[$urandom_range(7, 1)] = 1'b0;
        bus(1, bnr_pkg::ADDR_ROUTE, route);
        bus(1, bnr_pkg::ADDR_VEN, {24'h0, ven});
        for (int l = 1; l <= 7; l++) begin
            raise <= 7'h01 << (l - 1);
            delay <= 4'($urandom_range(6, 0));
            @(posedge core_clk);
            raise <= 7'h00;
            bus(0, bnr_pkg::ADDR_PEND, ven[l] ? 32'h1 << sb[l] : 32'h0);
            bus(1, bnr_pkg::ADDR_IEN, 32'(l % 2) << bnr_pkg::ST_VEC);
            bus(1, bnr_pkg::ADDR_ACK, l);
            for (n = 0; n < 30 && acks < l; n++) @(posedge core_clk);
            if (acks < l) hang();
            bus(0, bnr_pkg::ADDR_VEC, {24'h0, VBASE ^ 8'(l)});
            bus(0, bnr_pkg::ADDR_STAT, 32'h10);
            #1;
            cmp(irq, l % 2);
            bus(1, bnr_pkg::ADDR_CLR, 32'h10);
            bus(0, bnr_pkg::ADDR_PEND, 32'h0);
            #1;
            cmp(irq, 1'b0);
        end
        tally_and_finish();
    end
endmodule : tb

bind bnr_router bnr_props i_props (.core_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid,
    .iack_level, .iack_req, .iack_done, .sysfail, .acfail, .abort_sw, .sbus_irq, .proc_irl, .board_reset);
`default_nettype wire
